// file: pkg/tbid_pkg.sv
// shared constants and carrier types for the instruction decoder
package tbid_pkg;

  // ****************************************
  // instruction word and fields
  // ****************************************
  localparam int INSTR_W       = 12;
  localparam int FILE_W        = 5;
  localparam int BIT_W         = 3;
  localparam int LIT8_W        = 8;
  localparam int LIT9_W        = 9;
  localparam int BYTE_OPC_LSB  = 6;
  localparam int DEST_POS      = 5;
  localparam int BIT_NUM_LSB   = 5;
  localparam int LIT_OPC_LSB   = 8;
  localparam int JUMP_OPC_LSB  = 9;
  localparam logic [1:0] GRP_PREFIX_BYTE = 2'h0;
  localparam logic [1:0] GRP_PREFIX_BIT  = 2'h1;
  localparam logic [2:0] JUMP_PREFIX     = 3'h5;
  localparam logic [FILE_W-1:0] FILE_ADDR_MAX = 5'h1F;

  // ****************************************
  // instruction cycle timing
  // ****************************************
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [31:0] CYCLE_CNT_RST = 32'h0000_0000;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INSTR  = 12'h008;
  localparam logic [11:0] ADDR_CYCLES = 12'h00C;
  localparam logic [1:0]  CTRL_RST    = 2'h1;
  localparam int CTRL_RUN_POS   = 0;
  localparam int CTRL_NOEXT_POS = 1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    TBID_GRP_BYTE = 2'h0,
    TBID_GRP_BIT  = 2'h1,
    TBID_GRP_LIT  = 2'h2
  } tbid_group_e;

  typedef enum logic [1:0] {
    TBID_Q1 = 2'h0,
    TBID_Q2 = 2'h1,
    TBID_Q3 = 2'h3,
    TBID_Q4 = 2'h2
  } tbid_phase_e;

  typedef struct packed {
    tbid_group_e         group;
    logic [5:0]          opcode;
    logic                dest_file;
    logic [FILE_W-1:0]   file_addr;
    logic [BIT_W-1:0]    bit_num;
    logic [LIT9_W-1:0]   literal;
    logic                lit_is_9;
    logic                valid;
  } tbid_dec_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tbid_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } tbid_apb_rsp_s;

endpackage

// file: logic/tbid_decoder.sv
// twelve-bit instruction decoder with cycle sequencer and apb registers
// Behaviour
// - accept twelve-bit words: opcode plus one or more operand fields
// - classify each word byte, bit or literal/control; extract operands per group
// - file address operand selects one of 32 registers, 0x00 to 0x1F
// - byte group: destination 0 targets accumulator, 1 targets file register
// - bit group: bit number picks bit of addressed 8-bit file register
// - literal group: extract eight- or nine-bit constant by format
// - one instruction cycle, two when condition true or program counter changes; with the CTRL_NOEXT_POS bit set the decoder keeps it at one
// - instruction cycle is four consecutive oscillator periods
// - don't-care bits ignored by decoder; producers should fill zero
// - byte words: opcode 11..6, destination bit 5, address 4..0
// - literal words except jump: opcode 11..8, immediate 7..0
// - jump word: opcode 11..9, nine-bit target 8..0
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
module tbid_decoder
  import tbid_pkg::*;
#(
  parameter int CYCLE_CNT_W = 32
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire tbid_apb_req_s        apb_req,
  output tbid_apb_rsp_s             apb_rsp,
  input  wire logic [INSTR_W-1:0]   instr_word,
  input  wire logic                 instr_valid,
  input  wire logic                 cond_true,
  input  wire logic                 pc_write,
  output tbid_dec_s                 dec,
  output tbid_phase_e               phase,
  output logic                      cycle_end,
  output logic                      fetch_stall,
  output logic                      fetch_flush
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tbid_phase_e         phase;
    logic                second;
    logic                extra_req;
    logic [INSTR_W-1:0]  instr;
    tbid_dec_s           dec;
    logic                cycle_end;
    logic                stall;
    logic                flush;
    logic [1:0]          ctrl;
    logic [CYCLE_CNT_W-1:0] cycles;
    tbid_apb_rsp_s       rsp;
  } tbid_state_s;

  tbid_state_s st;
  tbid_state_s next_st;
  tbid_dec_s   next_dec;
  logic        acc;
  logic        extra;
  logic        take;
  logic [1:0]  grp_prefix;
  logic        is_jump;
  logic [31:0] status_word;
  logic [31:0] cycles_word;

  // ****************************************
  // reset value
  // ****************************************
  localparam tbid_state_s ST_RST = '{
    phase:     TBID_Q1,
    second:    1'b0,
    extra_req: 1'b0,
    instr:     '0,
    dec:       '0,
    cycle_end: 1'b0,
    stall:     1'b0,
    flush:     1'b0,
    ctrl:      CTRL_RST,
    cycles:    CYCLE_CNT_W'(CYCLE_CNT_RST),
    rsp:       '0
  };

  // ****************************************
  // elaboration checks
  // ****************************************
  if (CYCLE_CNT_W < 1 || CYCLE_CNT_W > 32) begin : g_cnt_w_chk
    $error("cycle counter width must lie between 1 and 32");
  end

  // ****************************************
  // qualifiers
  // ****************************************
  always_comb begin
    grp_prefix  = instr_word[INSTR_W-1 -: 2];
    is_jump     = instr_word[INSTR_W-1:JUMP_OPC_LSB] == JUMP_PREFIX;
    acc         = apb_req.psel && apb_req.penable && !st.rsp.pready;
    extra       = (st.extra_req || cond_true || pc_write) && !st.ctrl[CTRL_NOEXT_POS];
    take        = st.ctrl[CTRL_RUN_POS] && instr_valid;
    status_word = {26'h0, st.dec.group, st.stall, st.second, st.phase};
    cycles_word = 32'(st.cycles);
  end

  // ****************************************
  // field decode
  // ****************************************
  always_comb begin
    next_dec           = '0;
    next_dec.valid     = 1'b1;
    next_dec.file_addr = instr_word[FILE_W-1:0];
    if (grp_prefix == GRP_PREFIX_BYTE) begin
      next_dec.group     = TBID_GRP_BYTE;
      next_dec.opcode    = instr_word[INSTR_W-1:BYTE_OPC_LSB];
      next_dec.dest_file = instr_word[DEST_POS];
    end else if (grp_prefix == GRP_PREFIX_BIT) begin
      next_dec.group     = TBID_GRP_BIT;
      next_dec.opcode    = {2'h0, instr_word[INSTR_W-1:LIT_OPC_LSB]};
      next_dec.bit_num   = instr_word[BIT_NUM_LSB +: BIT_W];
      next_dec.dest_file = 1'b1;
    end else begin
      next_dec.group     = TBID_GRP_LIT;
      next_dec.file_addr = '0;
      if (is_jump) begin
        next_dec.opcode   = {3'h0, instr_word[INSTR_W-1:JUMP_OPC_LSB]};
        next_dec.literal  = instr_word[LIT9_W-1:0];
        next_dec.lit_is_9 = 1'b1;
      end else begin
        next_dec.opcode  = {2'h0, instr_word[INSTR_W-1:LIT_OPC_LSB]};
        next_dec.literal = {1'b0, instr_word[LIT8_W-1:0]};
      end
    end
  end

  // ****************************************
  // sequencer and registers
  // ****************************************
  always_comb begin
    next_st           = st;
    next_st.cycle_end = 1'b0;
    next_st.flush     = 1'b0;
    // condition seen during the cycle, end-of-cycle clear wins over set
    if (!st.second && (cond_true || pc_write)) begin
      next_st.extra_req = 1'b1;
    end
    unique case (st.phase)
      TBID_Q1: next_st.phase = TBID_Q2;
      TBID_Q2: next_st.phase = TBID_Q3;
      TBID_Q3: next_st.phase = TBID_Q4;
      TBID_Q4: begin
        next_st.phase     = TBID_Q1;
        next_st.cycle_end = 1'b1;
        next_st.cycles    = st.cycles + CYCLE_CNT_W'(1);
        next_st.extra_req = 1'b0;
        if (!st.second && st.dec.valid && extra) begin
          next_st.second = 1'b1;
          next_st.stall  = 1'b1;
          next_st.flush  = 1'b1;
          next_st.dec    = '0;
        end else begin
          next_st.second = 1'b0;
          next_st.stall  = 1'b0;
          if (take) begin
            next_st.instr = instr_word;
            next_st.dec   = next_dec;
          end else begin
            next_st.dec = '0;
          end
        end
      end
    endcase

    // ****************************************
    // register access, one wait state
    // ****************************************
    next_st.rsp.pready  = acc;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata  = '0;
    if (acc) begin
      unique case (apb_req.paddr)
        ADDR_CTRL: begin
          next_st.rsp.prdata = {30'h0, st.ctrl};
          if (apb_req.pwrite) begin
            next_st.ctrl = apb_req.pwdata[1:0];
          end
        end
        ADDR_STATUS: begin
          next_st.rsp.prdata = status_word;
        end
        ADDR_INSTR: begin
          next_st.rsp.prdata = {20'h0, st.instr};
        end
        ADDR_CYCLES: begin
          next_st.rsp.prdata = cycles_word;
          if (apb_req.pwrite) begin
            next_st.cycles = CYCLE_CNT_W'(CYCLE_CNT_RST);
          end
        end
        default: begin
          next_st.rsp.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign apb_rsp     = st.rsp;
  assign dec         = st.dec;
  assign phase       = st.phase;
  assign cycle_end   = st.cycle_end;
  assign fetch_stall = st.stall;
  assign fetch_flush = st.flush;

endmodule

// file: verification/tbid_decoder_props.sv
// port assertions for the instruction decoder
`timescale 1ns/10ps
module tbid_decoder_props
  import tbid_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic               pclk,
  input wire logic               presetn,
  input wire tbid_dec_s          dec,
  input wire tbid_phase_e        phase,
  input wire logic               cycle_end,
  input wire logic               fetch_stall,
  input wire logic               fetch_flush,
  input wire tbid_apb_req_s      apb_req,
  input wire tbid_apb_rsp_s      apb_rsp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] tw;
  logic        de;
  always_ff @(posedge pclk) tw <= instr_word;
  assign de = cycle_end && dec.valid;

  phase_walk_a: assert property (phase == TBID_Q1 |=> phase == TBID_Q2 ##1
    phase == TBID_Q3 ##1 phase == TBID_Q4 ##1 phase == TBID_Q1) else $error("phase walk");
  dec_hold_a: assert property (cycle_end |=> $stable(dec) [*3])
    else $error("decode not held");
  grp_sort_a: assert property (de |-> dec.group == (tw[11:10] == GRP_PREFIX_BYTE ?
    TBID_GRP_BYTE : tw[11:10] == GRP_PREFIX_BIT ? TBID_GRP_BIT : TBID_GRP_LIT))
    else $error("bad group");
  file_addr_a: assert property (de && dec.group != TBID_GRP_LIT |->
    dec.file_addr == tw[4:0]) else $error("bad file address");
  dest_sel_a: assert property (de && dec.group == TBID_GRP_BYTE |->
    dec.dest_file == tw[5]) else $error("bad destination");
  bit_pick_a: assert property (de && dec.group == TBID_GRP_BIT |->
    dec.bit_num == tw[7:5]) else $error("bad bit number");
  lit_width_a: assert property (de && dec.group == TBID_GRP_LIT |->
    dec.literal == (tw[11:9] == JUMP_PREFIX ? tw[8:0] : {1'b0, tw[7:0]}))
    else $error("bad literal");
  extra_cyc_a: assert property ($rose(fetch_stall) |-> fetch_flush && cycle_end ##1
    (fetch_stall && !fetch_flush) [*3] ##1 !fetch_stall) else $error("bad extra cycle");
  opc_field_a: assert property (de |-> dec.opcode ==
    (tw[11:10] == GRP_PREFIX_BYTE ? tw[11:6] : tw[11:9] == JUMP_PREFIX ?
    {3'h0, tw[11:9]} : {2'h0, tw[11:8]})) else $error("bad opcode field");
  apb_ack_a: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=>
    apb_rsp.pready) else $error("bus access not answered");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  err_resp_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("bad error response");
  cover property (de && dec.group == TBID_GRP_BIT);
  cover property (de && dec.lit_is_9);
  cover property ($rose(fetch_stall));
endmodule

// file: verification/tbid_fetch_model.sv
// fetch and datapath stand-in feeding the decoder
`timescale 1ns/10ps
module tbid_fetch_model
  import tbid_pkg::*;
(
  input  wire logic [11:0] word,
  input  wire logic [1:0]  flag,
  input  wire logic        pclk,
  input  wire logic        fetch_stall,
  output logic [11:0]      instr_word = 12'h000,
  output logic             instr_valid = 1'b0,
  output logic             cond_true = 1'b0,
  output logic             pc_write = 1'b0
);
  always @(posedge pclk) begin
    instr_valid <= !fetch_stall;
    instr_word  <= fetch_stall ? ~instr_word : word;
    cond_true   <= flag[0];
    pc_write    <= flag[1];
  end
endmodule

// file: verification/tbid_decoder_test.sv
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tbid_decoder_test
  import tbid_pkg::*;
;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  tbid_apb_req_s req = '0;
  tbid_apb_rsp_s rsp;
  tbid_dec_s     dec;
  tbid_phase_e   phase;
  logic [11:0]   iw;
  logic [11:0]   word = 12'h000;
  logic [1:0]    flag = 2'h0;
  logic          iv, ct, pw, ce, st, fl;
  logic [32:0]   rd;
  logic [32:0]   cyc;
  logic          noext = 1'b0;
  int            fails = 0, n_compared = 0, tick = 0;
  initial forever #4 pclk = ~pclk;
  tbid_decoder i_tbid_decoder (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .instr_word(iw), .instr_valid(iv), .cond_true(ct), .pc_write(pw),
    .dec(dec), .phase(phase), .cycle_end(ce), .fetch_stall(st), .fetch_flush(fl));
  tbid_fetch_model i_tbid_fetch_model (.pclk(pclk), .word(word), .flag(flag),
    .fetch_stall(st), .instr_word(iw), .instr_valid(iv), .cond_true(ct), .pc_write(pw));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    tick++;
    if (tick == 5000) begin
      fails++;
      wrap_up;
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk) req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = {rsp.pslverr, rsp.prdata};
    req <= '0;
  endtask
  task automatic go(input logic [11:0] w, input logic [1:0] f, input tbid_group_e g,
                    input logic [9:0] v);
    do @(negedge pclk); while (!(ce === 1'b1 && st === 1'b0));
    @(posedge pclk) word <= w;
    do @(negedge pclk); while (ce !== 1'b1);
    chk({dec.valid, dec.group, g == TBID_GRP_LIT ? {dec.lit_is_9, dec.literal} :
      g == TBID_GRP_BIT ? {2'h0, dec.bit_num, dec.file_addr} :
      {4'h0, dec.dest_file, dec.file_addr}}, {1'b1, g, v});
    if (f != 2'h0) begin
      @(posedge pclk) flag <= f;
      do @(negedge pclk); while (ce !== 1'b1);
      chk({st, fl, dec.valid}, noext ? 3'h1 : 3'h6);
      @(posedge pclk) flag <= 2'h0;
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, {31'h0, CTRL_RST});
    go(12'h1AF, 2'h0, TBID_GRP_BYTE, 10'h02F);
    go(12'h01F, 2'h0, TBID_GRP_BYTE, 10'h01F);
    go(12'h5E3, 2'h0, TBID_GRP_BIT, 10'h0E3);
    go(12'hFAF, 2'h1, TBID_GRP_LIT, 10'h0AF);
    go(12'hA55, 2'h2, TBID_GRP_LIT, 10'h255);
    go(12'h9FF, 2'h0, TBID_GRP_LIT, 10'h0FF);
    go(12'hBFF, 2'h3, TBID_GRP_LIT, 10'h3FF);
    apb(1'b0, ADDR_INSTR, 32'h0);
    chk(rd, 33'h0_0000_0BFF);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 33'h1_0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 33'h3);
    noext = 1'b1;
    go(12'h0E5, 2'h1, TBID_GRP_BYTE, 10'h025);
    apb(1'b1, ADDR_CYCLES, 32'h0);
    apb(1'b0, ADDR_CYCLES, 32'h0);
    chk({1'b0, rd[32:1]}, 33'h0);
    cyc = rd;
    apb(1'b0, ADDR_CYCLES, 32'h0);
    chk(rd, cyc + 33'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) do @(negedge pclk); while (ce !== 1'b1);
    chk({32'h0, dec.valid}, 33'h0);
    wrap_up;
  end
endmodule
bind tbid_decoder tbid_decoder_props i_tbid_decoder_props (.pclk(pclk), .presetn(presetn),
  .instr_word(instr_word), .dec(dec), .phase(phase), .cycle_end(cycle_end),
  .fetch_stall(fetch_stall), .fetch_flush(fetch_flush), .apb_req(apb_req), .apb_rsp(apb_rsp));
